// ### hw/pmrc_top.v
// Power mode and reset control: idle, stop, reset entry and exit
// Assumes a Wishbone classic master, a core that pulses insn_done at
// the end of each instruction, and external reset sources as levels
//
// Implementation choice: the Wishbone slave port.
`include "pmrc_map.vh"

module pmrc_top #(
  parameter WDT_DIV   = `PMRC_WDT_DIV,
  parameter WDT_LIMIT = 16'hFFFF,
  parameter MCD_CYC   = `PMRC_MCD_CYC
) (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        rst,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [9:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  output wire        wb_err_o,
  // Core side
  input  wire        insn_done,
  input  wire        irq_enabled,
  input  wire        wdt_kick,
  output wire        cpu_halt,
  output wire        cpu_clk_en,
  output wire        periph_clk_en,
  output wire        int_osc_en,
  output wire        core_reset,
  output wire        sysclk_sel_int,
  output wire        irq_mask_all,
  output wire [15:0] pc_load_value,
  output wire        sp_reinit,
  // Reset sources
  input  wire        por_req,
  input  wire        vdd_fail,
  input  wire        ext_rst_n,
  input  wire        clk_alive,
  // Reset pin and port pins
  output wire        rst_n_o,
  output wire        rst_n_oe,
  output wire [7:0]  port_latch_rst,
  output wire        port_open_drain,
  output wire        weak_pullup_en,
  // Status
  output reg         idle_active,
  output reg         stop_active,
  output reg  [7:0]  general_flags
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam [1:0] ST_RUN  = 2'b00;
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_STOP = 2'b10;

  // Reset values of the config bits and the reset stretch length
  localparam [7:0] CFG_RST  = `PMRC_CFG_RST;
  localparam [2:0] RST_HOLD = 3'h`PMRC_RST_HOLD;

  reg  [1:0]  state;
  reg  [1:0]  next_state;
  reg         idle_req;
  reg         stop_req;
  reg         wdt_en;
  reg         mcd_en;
  reg  [15:0] wdt_cnt;
  reg  [15:0] mcd_cnt;
  reg  [2:0]  hold_cnt;
  reg         supply_rst;
  reg         wdt_fired;
  reg         mcd_fired;
  reg         wr_idle;
  reg         wr_stop;
  wire        wdt_tick;
  wire        any_src;
  wire        in_reset;
  wire        wb_req;
  wire        hit_pctl;
  wire        hit_cfg;
  wire        hit_stat;
  wire        wb_wr;
  wire        wr_pctl;
  wire        wr_cfg;
  wire        wdt_run;
  wire [31:0] stat_word;

  // Address decode shared by reads and writes
  function [1:0] dec;
    input [9:0] a;
    begin
      if (a == `PMRC_PCTL_ADDR)
        dec = 2'h1;
      else if (a == `PMRC_CFG_ADDR)
        dec = 2'h2;
      else if (a == `PMRC_STAT_ADDR)
        dec = 2'h3;
      else
        dec = 2'h0;
    end
  endfunction

  assign wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign hit_pctl = dec(wb_adr_i) == 2'h1;
  assign hit_cfg  = dec(wb_adr_i) == 2'h2;
  assign hit_stat = dec(wb_adr_i) == 2'h3;
  assign wb_err_o = 1'b0;
  // Writes land at the edge where the master sees ack high
  assign wb_wr    = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
  assign wr_pctl  = wb_wr & hit_pctl;
  assign wr_cfg   = wb_wr & hit_cfg;

  // ----------------------------------------------------------------
  // Reset sequencing
  // ----------------------------------------------------------------
  // Any source entering reset; watchdog and clock detector are internal
  assign any_src  = por_req | vdd_fail | ~ext_rst_n | wdt_fired | mcd_fired;
  assign in_reset = any_src | (hold_cnt != 3'h0);

  // Stretch each reset so the core sees a clean pulse
  // Pin flag outlives a supply source by the hold count
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hold_cnt   <= RST_HOLD;
      supply_rst <= 1'b1;
    end else if (any_src) begin
      hold_cnt   <= RST_HOLD;
      supply_rst <= por_req | vdd_fail | (supply_rst & (hold_cnt != 3'h0));
    end else if (hold_cnt != 3'h0) begin
      hold_cnt   <= hold_cnt - 3'h1;
    end else begin
      supply_rst <= 1'b0;
    end
  end

  assign core_reset      = in_reset;
  assign irq_mask_all    = in_reset;
  assign sp_reinit       = in_reset;
  assign pc_load_value   = `PMRC_RESET_VEC;
  assign sysclk_sel_int  = in_reset;
  assign port_latch_rst  = `PMRC_PORT_RST;
  assign port_open_drain = in_reset;
  assign weak_pullup_en  = 1'b1;
  // Open-drain reset pin, only for supply resets
  assign rst_n_o         = 1'b0;
  assign rst_n_oe        = supply_rst & in_reset;

  // ----------------------------------------------------------------
  // Power mode state machine
  // ----------------------------------------------------------------
  always @* begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (stop_req && insn_done)
          next_state = ST_STOP;
        else if (idle_req && insn_done)
          next_state = ST_IDLE;
      end
      ST_IDLE: begin
        if (irq_enabled)
          next_state = ST_RUN;
      end
      ST_STOP: begin
        next_state = ST_STOP;
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= ST_RUN;
    end else if (in_reset) begin
      state <= ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // Mode outputs; peripherals keep running in idle
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      idle_active <= 1'b0;
      stop_active <= 1'b0;
    end else begin
      idle_active <= ~in_reset & (next_state == ST_IDLE);
      stop_active <= ~in_reset & (next_state == ST_STOP);
    end
  end

  assign cpu_halt      = (state != ST_RUN) | in_reset;
  assign cpu_clk_en    = (state == ST_RUN) & ~in_reset;
  assign periph_clk_en = (state != ST_STOP);
  assign int_osc_en    = (state != ST_STOP);

  // ----------------------------------------------------------------
  // Power control register and configuration
  // ----------------------------------------------------------------
  always @* begin
    wr_idle = wr_pctl & wb_dat_i[`PMRC_IDLE_BIT];
    wr_stop = wr_pctl & wb_dat_i[`PMRC_STOP_BIT];
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      idle_req      <= 1'b0;
      stop_req      <= 1'b0;
      general_flags <= 8'h00;
      wdt_en        <= CFG_RST[`PMRC_CFG_WDT_BIT];
      mcd_en        <= CFG_RST[`PMRC_CFG_MCD_BIT];
    end else if (in_reset) begin
      idle_req      <= 1'b0;
      stop_req      <= 1'b0;
      general_flags <= `PMRC_PCTL_RST;
      wdt_en        <= CFG_RST[`PMRC_CFG_WDT_BIT];
      mcd_en        <= CFG_RST[`PMRC_CFG_MCD_BIT];
    end else begin
      // Low two bits never stored; they read as zero
      if (wr_pctl)
        general_flags <= {wb_dat_i[`PMRC_GF_MSB:`PMRC_GF_LSB], 2'b00};
      // Request bits: set by write; stop cleared on stop entry, idle on stop entry or interrupt wake
      // A write in the same cycle as a clear wins
      if (wr_stop)
        stop_req <= 1'b1;
      else if (state == ST_STOP)
        stop_req <= 1'b0;
      if (wr_idle)
        idle_req <= 1'b1;
      else if (state == ST_IDLE && irq_enabled)
        idle_req <= 1'b0;
      else if (stop_req && insn_done)
        idle_req <= 1'b0;
      if (wr_cfg) begin
        wdt_en <= wb_dat_i[`PMRC_CFG_WDT_BIT];
        mcd_en <= wb_dat_i[`PMRC_CFG_MCD_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Watchdog, clocked at system clock over twelve
  // ----------------------------------------------------------------
  // Watchdog ticks stop with the digital peripherals in stop
  assign wdt_run = wdt_en & (state != ST_STOP);

  pmrc_div #(
    .DIV (WDT_DIV)
  ) u_div (
    .clk_sys (clk_sys),
    .rst     (rst),
    .clr     (in_reset),
    .run     (wdt_run),
    .tick    (wdt_tick)
  );

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wdt_cnt   <= 16'h0000;
      wdt_fired <= 1'b0;
    end else if (in_reset || wdt_kick || !wdt_en) begin
      wdt_cnt   <= 16'h0000;
      wdt_fired <= 1'b0;
    end else if (wdt_tick) begin
      if (wdt_cnt == WDT_LIMIT[15:0]) begin
        wdt_fired <= 1'b1;
      end else begin
        wdt_cnt   <= wdt_cnt + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Missing clock one-shot: counts cycles with no clock activity
  // ----------------------------------------------------------------
  // Detector cannot run without the clock,
  // so clk_alive stands in for its edges
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mcd_cnt   <= 16'h0000;
      mcd_fired <= 1'b0;
    end else if (in_reset || clk_alive || !mcd_en) begin
      mcd_cnt   <= 16'h0000;
      mcd_fired <= 1'b0;
    end else if (mcd_cnt >= MCD_CYC[15:0]) begin
      mcd_fired <= 1'b1;
    end else begin
      mcd_cnt   <= mcd_cnt + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Wishbone answer: one-cycle ack, reads of mode bits give zero
  // ----------------------------------------------------------------
  // Status word: supply flag, reset, stop, idle
  assign stat_word = {28'h0000000, supply_rst, in_reset, stop_active, idle_active};

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        if (hit_pctl)
          wb_dat_o <= {24'h000000, general_flags[7:2], 2'b00};
        else if (hit_cfg)
          wb_dat_o <= {30'h00000000, mcd_en, wdt_en};
        else if (hit_stat)
          wb_dat_o <= stat_word;
        else
          wb_dat_o <= 32'h00000000;
      end
    end
  end
endmodule

// ### inc/pmrc_map.vh
// Constants for the power mode and reset control block
// Assumes a 25 MHz system clock and a Wishbone register window
`ifndef PMRC_MAP_VH
`define PMRC_MAP_VH
// ----------------------------------------------------------------
// Register offsets (byte addresses; PMRC_PCTL_IDX is a word index)
// ----------------------------------------------------------------
`define PMRC_PCTL_IDX     8'h87
`define PMRC_PCTL_ADDR    10'h21C
`define PMRC_CFG_ADDR     10'h220
`define PMRC_STAT_ADDR    10'h224
// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define PMRC_IDLE_BIT     0
`define PMRC_STOP_BIT     1
`define PMRC_GF_LSB       2
`define PMRC_GF_MSB       7
`define PMRC_PCTL_RST     8'h00
`define PMRC_CFG_WDT_BIT  0
`define PMRC_CFG_MCD_BIT  1
`define PMRC_CFG_RST      8'h03
`define PMRC_PORT_RST     8'hFF
`define PMRC_RESET_VEC    16'h0000
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PMRC_CLK_MHZ      25
`define PMRC_MCD_US       100
`define PMRC_MCD_CYC      (`PMRC_MCD_US * `PMRC_CLK_MHZ)
`define PMRC_WDT_DIV      12
`define PMRC_RST_HOLD     4
`endif

// ### hw/pmrc_div.v
// Clock enable divider for the watchdog tick
// Assumes one system clock; emits a one-cycle enable pulse
module pmrc_div #(
  parameter DIV = 12
) (
  // Clock and reset
  input  wire       clk_sys,
  input  wire       rst,
  // Control
  input  wire       clr,
  input  wire       run,
  // Tick out
  output reg        tick
);
  reg [7:0] cnt;

  // Count DIV cycles while running, then pulse
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt  <= 8'h00;
      tick <= 1'b0;
    end else if (clr) begin
      cnt  <= 8'h00;
      tick <= 1'b0;
    end else if (run) begin
      if (cnt == DIV[7:0] - 8'h01) begin
        cnt  <= 8'h00;
        tick <= 1'b1;
      end else begin
        cnt  <= cnt + 8'h01;
        tick <= 1'b0;
      end
    end else begin
      tick <= 1'b0;
    end
  end
endmodule

// ### tb/pmrc_props.sv
// Port checker for the power mode and reset control block
// Assumes one clock domain; bound onto pmrc_top at the foot
`include "pmrc_map.vh"
module pmrc_props (
  // Clock and reset
  input logic        clk_sys,
  input logic        rst,
  // Register bus
  input logic        wb_cyc_i,
  input logic        wb_stb_i,
  input logic        wb_we_i,
  input logic [9:0]  wb_adr_i,
  input logic [3:0]  wb_sel_i,
  input logic [31:0] wb_dat_i,
  input logic [31:0] wb_dat_o,
  input logic        wb_ack_o,
  // Core and reset sources
  input logic        insn_done,
  input logic        irq_enabled,
  input logic        por_req,
  input logic        vdd_fail,
  input logic        ext_rst_n,
  input logic        clk_alive,
  // Mode and reset outputs
  input logic        cpu_halt,
  input logic        periph_clk_en,
  input logic        int_osc_en,
  input logic        core_reset,
  input logic        irq_mask_all,
  input logic        sp_reinit,
  input logic        port_open_drain,
  input logic        weak_pullup_en,
  input logic        rst_n_oe,
  input logic        idle_active,
  input logic        stop_active
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic pend_idle;
  logic pend_stop;
  wire  pctl_wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0] & ~core_reset
                  & (wb_adr_i == `PMRC_PCTL_ADDR);
  // Mode request written but not yet taken
  always @(posedge clk_sys or posedge rst) begin
    if (rst | core_reset | idle_active | stop_active) begin
      pend_idle <= 1'b0;
      pend_stop <= 1'b0;
    end else if (pctl_wr) begin
      pend_idle <= wb_dat_i[0] & ~wb_dat_i[1];
      pend_stop <= wb_dat_i[1];
    end
  end
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_idle_entry: assert property (
    pend_idle && insn_done && !irq_enabled |-> ##[1:2] (idle_active && cpu_halt)) else $error("no idle");
  a_stop_entry: assert property (
    pend_stop && insn_done |-> ##[1:2] (stop_active && !idle_active && !int_osc_en && !periph_clk_en))
    else $error("no stop");
  a_idle_clocks: assert property (idle_active |-> periph_clk_en && int_osc_en) else $error("idle clocks");
  a_irq_wake: assert property (idle_active && irq_enabled |=> !idle_active) else $error("no wake");
  a_stop_holds: assert property (
    stop_active && !por_req && !vdd_fail && ext_rst_n && clk_alive |=> stop_active) else $error("stop left");
  a_reset_state: assert property (
    core_reset |-> cpu_halt && irq_mask_all && sp_reinit && port_open_drain) else $error("reset state");
  a_pullup_on: assert property (weak_pullup_en) else $error("pull-ups off");
  a_pin_supply: assert property (
    por_req || vdd_fail |-> ##[0:2] (core_reset && rst_n_oe)) else $error("pin not driven");
  a_pin_other: assert property (
    (!por_req && !vdd_fail && !rst_n_oe) ##1 (!por_req && !vdd_fail) |-> !rst_n_oe) else $error("pin driven");
  a_mode_read: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i == `PMRC_PCTL_ADDR |-> wb_dat_o[1:0] == 2'b00) else $error("mode bits read");
endmodule
bind pmrc_top pmrc_props u_pmrc_props (.*);

// ### tb/pmrc_core_model.sv
// Core stand-in: retires instructions and kicks the watchdog
// Assumes the bench drives irq_req and slow; block drives cpu_clk_en
module pmrc_core_model (
  // Clock and reset
  input  logic clk_sys,
  input  logic rst,
  // Block and bench controls
  input  logic cpu_clk_en,
  input  logic irq_req,
  input  logic slow,
  // To the block
  output logic insn_done,
  output logic irq_enabled,
  output logic wdt_kick
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;
  // Runs only while the core clock is enabled
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt       <= 4'h0;
      insn_done <= 1'b0;
      wdt_kick  <= 1'b0;
    end else begin
      cnt       <= cpu_clk_en ? cnt + 4'h1 : cnt;
      insn_done <= cpu_clk_en & (slow ? (cnt[1:0] == 2'h3) : cnt[0]);
      wdt_kick  <= cpu_clk_en & (cnt == 4'hF);
    end
  end
  assign irq_enabled = irq_req; // Enabled interrupt line
endmodule

// ### tb/testbench.sv
// Self-checking bench for the power mode and reset control block
// Assumes the core stand-in model and the bound port checker
`include "pmrc_map.vh"
`define CHK(got, exp, msg) begin \
  total_checks++; \
  if ((got) !== (exp)) begin \
    errors++; \
    $display("CHECK FAILED %0t %s", $time, msg); \
  end \
end
`define WAITC(c, lim, msg) begin \
  n = 0; \
  while (!(c) && n < lim) begin \
    @(posedge clk_sys); \
    n++; \
  end \
  `CHK((c), 1'b1, msg) \
end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0, rst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic        irq_req = 1'b0, slow = 1'b0, por_req = 1'b0, vdd_fail = 1'b0, ext_rst_n = 1'b1, clk_alive = 1'b1;
  logic [9:0]  wb_adr_i = 10'h000;
  logic [3:0]  wb_sel_i = 4'h1;
  logic [31:0] wb_dat_i = 32'h00000000;
  wire  [31:0] wb_dat_o;
  wire  [15:0] pc_load_value;
  wire  [7:0]  port_latch_rst, general_flags;
  wire         wb_ack_o, wb_err_o, insn_done, irq_enabled, wdt_kick, cpu_halt, cpu_clk_en;
  wire         periph_clk_en, int_osc_en, core_reset, sysclk_sel_int, irq_mask_all, sp_reinit;
  wire         rst_n_o, rst_n_oe, port_open_drain, weak_pullup_en, idle_active, stop_active;
  int          errors, total_checks, cycles, n;
  logic [7:0]  q;
  pmrc_top #(.WDT_LIMIT(16'h0004), .MCD_CYC(20)) u_pmrc_top (.*);
  pmrc_core_model u_pmrc_core_model (.*);
  // Clock and hang ceiling
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // One classic cycle, held until ack
  task automatic wbx(input logic w, input logic [9:0] a, input logic [7:0] d);
    int k;
    k = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h000000, d};
    do begin
      @(posedge clk_sys);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    `CHK(wb_ack_o, 1'b1, "no ack")
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_sys);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    `WAITC(core_reset === 1'b0, 20, "reset exit")
    wbx(1'b0, `PMRC_PCTL_ADDR, 8'h00);
    `CHK(q, 8'h00, "pctl reset")
    wbx(1'b0, `PMRC_CFG_ADDR, 8'h00);
    `CHK(q, 8'h03, "cfg reset")
    wbx(1'b0, 10'h3F0, 8'h00);
    `CHK(q, 8'h00, "unmapped")
    wbx(1'b1, `PMRC_CFG_ADDR, 8'h00);
    wbx(1'b1, `PMRC_PCTL_ADDR, 8'hA9);
    `WAITC(idle_active === 1'b1, 20, "idle entry")
    repeat (150) @(posedge clk_sys);
    `CHK({idle_active, periph_clk_en}, 2'b11, "idle held")
    wbx(1'b0, `PMRC_PCTL_ADDR, 8'h00);
    `CHK(q, 8'hA8, "mode bits")
    irq_req <= 1'b1;
    `WAITC(idle_active === 1'b0, 4, "irq wake")
    irq_req <= 1'b0;
    `CHK({cpu_halt, general_flags}, 9'h0A8, "resume")
    slow <= 1'b1;
    wbx(1'b1, `PMRC_CFG_ADDR, 8'h01);
    wbx(1'b1, `PMRC_PCTL_ADDR, 8'hFD);
    `WAITC(idle_active === 1'b1, 20, "idle again")
    `WAITC(core_reset === 1'b1, 80, "watchdog")
    `WAITC(core_reset === 1'b0, 20, "wdt exit")
    `CHK({idle_active, general_flags}, 9'h000, "after wdt")
    wbx(1'b0, `PMRC_CFG_ADDR, 8'h00);
    `CHK(q, 8'h03, "cfg after wdt")
    slow <= 1'b0;
    wbx(1'b1, `PMRC_CFG_ADDR, 8'h00);
    irq_req <= 1'b1;
    wbx(1'b1, `PMRC_PCTL_ADDR, 8'h03);
    `WAITC(stop_active === 1'b1, 20, "stop entry")
    `CHK({idle_active, int_osc_en}, 2'b00, "stop wins")
    repeat (100) @(posedge clk_sys);
    `CHK(stop_active, 1'b1, "irq in stop")
    wbx(1'b0, `PMRC_STAT_ADDR, 8'h00);
    `CHK(q, 8'h02, "stop status")
    irq_req   <= 1'b0;
    ext_rst_n <= 1'b0;
    `WAITC(core_reset === 1'b1, 4, "ext reset")
    `CHK(rst_n_oe, 1'b0, "ext pin")
    ext_rst_n <= 1'b1;
    `WAITC(core_reset === 1'b0, 20, "ext exit")
    `CHK(stop_active, 1'b0, "stop ended")
    wbx(1'b1, `PMRC_CFG_ADDR, 8'h02);
    wbx(1'b1, `PMRC_PCTL_ADDR, 8'h02);
    `WAITC(stop_active === 1'b1, 20, "stop entry")
    clk_alive <= 1'b0;
    repeat (10) @(posedge clk_sys);
    `CHK(core_reset, 1'b0, "early mcd")
    `WAITC(core_reset === 1'b1, 20, "mcd reset")
    `CHK(rst_n_oe, 1'b0, "mcd pin")
    clk_alive <= 1'b1;
    `WAITC(core_reset === 1'b0, 20, "mcd exit")
    for (int i = 0; i < 2; i++) begin
      por_req  <= (i == 1);
      vdd_fail <= (i == 0);
      `WAITC(rst_n_oe === 1'b1, 4, "supply pin")
      `CHK({core_reset, irq_mask_all, sp_reinit, sysclk_sel_int}, 4'hF, "reset outs")
      `CHK({port_latch_rst, port_open_drain, weak_pullup_en}, 10'h3FF, "ports")
      `CHK(pc_load_value, 16'h0000, "vector")
      wbx(1'b1, `PMRC_PCTL_ADDR, 8'hFC);
      wbx(1'b0, `PMRC_PCTL_ADDR, 8'h00);
      `CHK(q, 8'h00, "write in reset")
      wbx(1'b0, `PMRC_STAT_ADDR, 8'h00);
      `CHK(q, 8'h0C, "reset status")
      `CHK({wb_err_o, rst_n_o}, 2'b00, "tied outs")
      por_req  <= 1'b0;
      vdd_fail <= 1'b0;
      `WAITC(core_reset === 1'b0, 20, "supply exit")
      `CHK({rst_n_oe, weak_pullup_en}, 2'b01, "pin released")
    end
    report_and_stop();
  end
endmodule
